// [hdl/swt_top.sv]
// Notes on behaviour
// - time-out while awake without clear issues a device reset pulse
// - counter advances on low-frequency oscillator ticks, not the bus clock
// - mode 11 keeps the timer active always, sleep included
// - mode 10 runs awake, disabled in sleep
// - mode 01 follows the software enable bit
// - enable bit ignored in modes 00 and 1x; 00 disables
// - period code selects 1:32 doubling up to 1:8388608 at code 10010
// - codes 10011 to 11111 act as 1:32
// - period select resets to 01011, 1:65536, about 2 s
// - count cleared on reset, clear, sleep edges, osc fail, disable, start-up
// - sleep entry clears count; enabled timer resumes from zero
// - crystal source holds count cleared until start-up timer ends
// - time-out in sleep wakes device and updates status flags
// - oscillator divider changes leave the count alone
// - sleep entry clears power-down flag and sets time-out flag
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module swt_top #(
  parameter int CNT_W = swt_pkg::CNT_W
) (
  input wire logic MCLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // device side
  input wire logic [1:0] SUPERVISION_MODE_CONFIG,
  input wire logic LOW_FREQ_INTERNAL_OSC,
  input wire logic CLEAR_SUPERVISION_INSTRUCTION,
  input wire logic SLEEP_ENTER,
  input wire logic SLEEP_ACTIVE,
  input wire logic OSC_FAIL,
  input wire logic OSCILLATOR_STARTUP_TIMER,
  input wire logic CRYSTAL_CLOCK_SOURCE,
  output logic DEVICE_RESET,
  output logic WAKE_REQUEST,
  output logic TIMEOUT_STATUS_FLAG,
  output logic POWERDOWN_STATUS_FLAG,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_in;
  logic [1:0] mode_s;
  logic lfosc_s;
  logic clr_s;
  logic sleep_enter_s;
  logic asleep_s;
  logic osc_fail_s;
  logic ost_s;
  logic crystal_s;

  // gather pins for one synchroniser bank
  assign raw_in = {SUPERVISION_MODE_CONFIG, LOW_FREQ_INTERNAL_OSC,
                   CLEAR_SUPERVISION_INSTRUCTION, SLEEP_ENTER, SLEEP_ACTIVE,
                   OSC_FAIL, OSCILLATOR_STARTUP_TIMER};
  assign mode_s = sync_in[7:6];
  assign lfosc_s = sync_in[5];
  assign clr_s = sync_in[4];
  assign sleep_enter_s = sync_in[3];
  assign asleep_s = sync_in[2];
  assign osc_fail_s = sync_in[1];
  assign ost_s = sync_in[0];

  swt_sync #(.W(NSYNC)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d(raw_in),
    .q(sync_in)
  );

  swt_sync #(.W(1)) u_sync_xtal (
    .clk(MCLK),
    .rst(RST),
    .d(CRYSTAL_CLOCK_SOURCE),
    .q(crystal_s)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic soft_en_q;
  logic [swt_pkg::PS_W-1:0] period_sel_q;
  logic [swt_pkg::IRQ_W-1:0] irq_status_q;
  logic [swt_pkg::IRQ_W-1:0] irq_status_d;
  logic [swt_pkg::IRQ_W-1:0] irq_mask_q;
  logic lfosc_q;
  logic asleep_q;
  logic sleep_enter_q;
  logic clr_q;
  logic xtal_hold_q;
  logic to_flag_q;
  logic pd_flag_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  swt_pkg::swt_apb_req_s req;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_irqs;
  logic hit_mask;
  logic hit_cnt;
  logic mapped;
  logic [31:0] rdata_d;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_irqs;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign acc = req.sel && req.enable && !PREADY;
  assign wr_acc = acc && req.write;
  assign rd_acc = acc && !req.write;
  assign hit_ctrl = req.addr == swt_pkg::ADDR_CONTROL;
  assign hit_stat = req.addr == swt_pkg::ADDR_STATUS;
  assign hit_irqs = req.addr == swt_pkg::ADDR_IRQ_STATUS;
  assign hit_mask = req.addr == swt_pkg::ADDR_IRQ_MASK;
  assign hit_cnt = req.addr == swt_pkg::ADDR_COUNT;
  assign mapped = hit_ctrl || hit_stat || hit_irqs || hit_mask || hit_cnt;
  // register strobes, taken on the access edge
  assign wr_ctrl = wr_acc && hit_ctrl;
  assign wr_mask = wr_acc && hit_mask;
  // a read of irq status clears it
  assign rd_irqs = rd_acc && hit_irqs;

  // ----------------------------------------------------------------
  // mode and enable
  // ----------------------------------------------------------------
  swt_pkg::swt_mode_e mode;
  logic active;
  logic [CNT_W-1:0] count;
  logic expire;

  assign mode = swt_pkg::swt_mode_e'(mode_s);
  assign active = (mode == swt_pkg::SWT_MODE_ALWAYS) ||
                  ((mode == swt_pkg::SWT_MODE_NO_SLEEP) && !asleep_s) ||
                  ((mode == swt_pkg::SWT_MODE_SOFT) && soft_en_q);

  // read mux, unused bits read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_d[swt_pkg::CTRL_EN_BIT] = soft_en_q;
      rdata_d[swt_pkg::CTRL_PS_LSB +: swt_pkg::PS_W] = period_sel_q;
    end else if (hit_stat) begin
      rdata_d[swt_pkg::ST_TO_BIT] = to_flag_q;
      rdata_d[swt_pkg::ST_PD_BIT] = pd_flag_q;
      rdata_d[swt_pkg::ST_ACTIVE_BIT] = active;
    end else if (hit_irqs) begin
      rdata_d[swt_pkg::IRQ_W-1:0] = irq_status_q;
    end else if (hit_mask) begin
      rdata_d[swt_pkg::IRQ_W-1:0] = irq_mask_q;
    end else if (hit_cnt) begin
      rdata_d[CNT_W-1:0] = count;
    end
  end

  // ----------------------------------------------------------------
  // prescale terminal count
  // ----------------------------------------------------------------
  logic ps_valid;
  logic [swt_pkg::PS_W-1:0] ps_eff;
  logic [CNT_W-1:0] terminal;

  // reserved codes fall back to the shortest period
  assign ps_valid = period_sel_q <= swt_pkg::PS_MAX_CODE;
  assign ps_eff = ps_valid ? period_sel_q : '0;
  // ratio 2^(5+code); terminal is ratio minus one
  assign terminal = (CNT_W'(1) << (CNT_W'(ps_eff) +
                    CNT_W'(swt_pkg::PRESCALE_BASE_LOG2))) - CNT_W'(1);

  // ----------------------------------------------------------------
  // clear conditions and counter
  // ----------------------------------------------------------------
  logic tick;
  logic sleep_entry;
  logic wake;
  logic clr_edge;
  logic sleep_clr;
  logic startup_clr;
  logic cnt_clr;

  assign tick = lfosc_s && !lfosc_q;
  assign sleep_entry = sleep_enter_s && !sleep_enter_q;
  assign wake = asleep_q && !asleep_s;
  // clear instruction acts once per rising edge of its pin
  assign clr_edge = clr_s && !clr_q;
  // both sleep edges restart the count from zero
  assign sleep_clr = sleep_entry || wake;
  // start-up timer running, or crystal wake still waiting for it
  assign startup_clr = ost_s || xtal_hold_q;
  // osc divider setting is no input here, so it cannot touch the count
  assign cnt_clr = clr_edge || sleep_clr || osc_fail_s || !active ||
                   startup_clr;

  swt_counter #(.CNT_W(CNT_W)) u_counter (
    .clk(MCLK),
    .rst(RST),
    .clr(cnt_clr),
    .run(active),
    .tick(tick),
    .terminal(terminal),
    .count(count),
    .expire(expire)
  );

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      lfosc_q <= 1'b0;
      asleep_q <= 1'b0;
      sleep_enter_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      lfosc_q <= lfosc_s;
      asleep_q <= asleep_s;
      sleep_enter_q <= sleep_enter_s;
      clr_q <= clr_s;
    end
  end

  // crystal wake: hold cleared until start-up timer drops
  always_ff @(posedge MCLK) begin
    if (RST) begin
      xtal_hold_q <= 1'b0;
    end else if (wake && crystal_s) begin
      xtal_hold_q <= 1'b1;
    end else if (!ost_s) begin
      xtal_hold_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      soft_en_q <= swt_pkg::EN_RESET;
      period_sel_q <= swt_pkg::PS_RESET;
    end else if (wr_ctrl) begin
      soft_en_q <= req.wdata[swt_pkg::CTRL_EN_BIT];
      period_sel_q <= req.wdata[swt_pkg::CTRL_PS_LSB +: swt_pkg::PS_W];
    end
  end

  // ----------------------------------------------------------------
  // time-out outcome and status flags
  // ----------------------------------------------------------------
  logic expire_awake;
  logic expire_asleep;

  assign expire_awake = expire && !asleep_s;
  assign expire_asleep = expire && asleep_s;

  // reset pulse when awake, wake request when asleep
  always_ff @(posedge MCLK) begin
    if (RST) begin
      DEVICE_RESET <= 1'b0;
      WAKE_REQUEST <= 1'b0;
    end else begin
      DEVICE_RESET <= expire_awake;
      WAKE_REQUEST <= expire_asleep;
    end
  end

  // active-low style flags: 1 = no event recorded
  always_ff @(posedge MCLK) begin
    if (RST) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end else if (expire_asleep) begin
      to_flag_q <= 1'b0;
      pd_flag_q <= 1'b0;
    end else if (sleep_entry) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b0;
    end else if (clr_edge) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask, cleared by read, set wins
  // ----------------------------------------------------------------
  logic [swt_pkg::IRQ_W-1:0] irq_set;

  // awake time-out in bit 0, sleep time-out in bit 1
  assign irq_set = {expire_asleep, expire_awake};
  assign irq_status_d = (rd_irqs ? '0 : irq_status_q) | irq_set;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_status_q <= '0;
      irq_mask_q <= swt_pkg::IRQ_MASK_RESET;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_mask) begin
        irq_mask_q <= req.wdata[swt_pkg::IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      IRQ <= 1'b0;
      TIMEOUT_STATUS_FLAG <= 1'b1;
      POWERDOWN_STATUS_FLAG <= 1'b1;
    end else begin
      PREADY <= acc;
      PSLVERR <= acc && !mapped;
      PRDATA <= rd_acc ? rdata_d : 32'h0000_0000;
      IRQ <= |(irq_status_d & irq_mask_q);
      TIMEOUT_STATUS_FLAG <= to_flag_q;
      POWERDOWN_STATUS_FLAG <= pd_flag_q;
    end
  end

endmodule : swt_top
`default_nettype wire

// [hdl/swt_pkg.sv]
package swt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [11:0] ADDR_COUNT = 12'h010;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int PS_W = 5;
  localparam logic [4:0] PS_RESET = 5'h0B;
  localparam logic [4:0] PS_MAX_CODE = 5'h12;
  localparam logic EN_RESET = 1'b0;
  localparam int PRESCALE_BASE_LOG2 = 5;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // status and interrupt bit positions
  // ----------------------------------------------------------------
  localparam int ST_TO_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int ST_ACTIVE_BIT = 2;
  localparam int IRQ_W = 2;
  localparam int IRQ_RESET_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LFOSC_KHZ = 31;
  localparam int MCLK_KHZ = 10000;
  localparam int MCLK_PER_LFOSC = MCLK_KHZ / LFOSC_KHZ;
  localparam int RESET_PULSE_CYCLES = 1;

  // ----------------------------------------------------------------
  // mode field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SWT_MODE_OFF = 2'h0,
    SWT_MODE_SOFT = 2'h1,
    SWT_MODE_NO_SLEEP = 2'h2,
    SWT_MODE_ALWAYS = 2'h3
  } swt_mode_e;

  // apb request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } swt_apb_req_s;

endpackage : swt_pkg

// [hdl/swt_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module swt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : swt_sync
`default_nettype wire

// [hdl/swt_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module swt_counter #(
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic run,
  input wire logic tick,
  input wire logic [CNT_W-1:0] terminal,
  output logic [CNT_W-1:0] count,
  output logic expire
);
  logic [CNT_W-1:0] count_d;
  logic hit;

  // terminal compare and next count
  assign hit = run && tick && (count == terminal);
  assign count_d = hit ? '0 : (count + {{(CNT_W-1){1'b0}}, 1'b1});

  // counts oscillator ticks, restarts at terminal count
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= hit;
      if (run && tick) begin
        count <= count_d;
      end
    end
  end
endmodule : swt_counter
`default_nettype wire

// [tb/swt_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module swt_top_checker #(
  parameter int CNT_W = swt_pkg::CNT_W
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [1:0] SUPERVISION_MODE_CONFIG,
  input wire logic LOW_FREQ_INTERNAL_OSC,
  input wire logic CLEAR_SUPERVISION_INSTRUCTION,
  input wire logic SLEEP_ENTER,
  input wire logic SLEEP_ACTIVE,
  input wire logic OSC_FAIL,
  input wire logic OSCILLATOR_STARTUP_TIMER,
  input wire logic CRYSTAL_CLOCK_SOURCE,
  input wire logic DEVICE_RESET,
  input wire logic WAKE_REQUEST,
  input wire logic TIMEOUT_STATUS_FLAG,
  input wire logic POWERDOWN_STATUS_FLAG,
  input wire logic IRQ
);
  // ----------------------------------------------------------------
  // bus and timer relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // bus answer comes one wait state after the access phase opens
  AST_READY_LATENCY: assert property ((PSEL && $rose(PENABLE)) |=> PREADY ##1 !PREADY)
    else $error("bus answer not one cycle after access phase");
  AST_SLVERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside answer");
  // time-out outputs
  AST_RESET_PULSE: assert property (DEVICE_RESET |=> !DEVICE_RESET)
    else $error("device reset longer than one cycle");
  AST_AWAKE_NO_WAKE: assert property ((!SLEEP_ACTIVE) [*8] |-> !WAKE_REQUEST)
    else $error("wake request while awake");
  AST_SLEEP_NO_RESET: assert property (SLEEP_ACTIVE [*8] |-> !DEVICE_RESET)
    else $error("device reset during sleep");
  AST_WAKE_FLAG: assert property (WAKE_REQUEST |-> ##[0:2] !TIMEOUT_STATUS_FLAG)
    else $error("time-out flag not updated by sleep time-out");
  AST_SLEEP_PD: assert property ($rose(SLEEP_ENTER) |-> ##[1:6] !POWERDOWN_STATUS_FLAG)
    else $error("power-down flag not cleared on sleep entry");
  AST_MODE10_SLEEP: assert property ((SUPERVISION_MODE_CONFIG == 2'h2 && SLEEP_ACTIVE) [*8]
    |-> !WAKE_REQUEST)
    else $error("timer active in sleep in mode 10");
  AST_OFF_QUIET: assert property ((SUPERVISION_MODE_CONFIG == 2'h0) [*8]
    |-> !DEVICE_RESET && !WAKE_REQUEST)
    else $error("time-out in mode 00");
  AST_FAIL_QUIET: assert property (OSC_FAIL [*8] |-> !DEVICE_RESET && !WAKE_REQUEST)
    else $error("time-out while oscillator failed");
  AST_STARTUP_QUIET: assert property (OSCILLATOR_STARTUP_TIMER [*8]
    |-> !DEVICE_RESET && !WAKE_REQUEST)
    else $error("time-out while start-up timer runs");
endmodule : swt_top_checker
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, osc = 1'b0, clr = 1'b0, slp_en = 1'b0, slp_act = 1'b0;
  logic ofail = 1'b0, oscillator_startup_timer = 1'b0, xtal = 1'b0, dev_rst, wake, to_flag, pd_flag, irq;
  logic [1:0] mode = 2'h0;
  int mismatches = 0, n_checks = 0, n_rst = 0, n_wake = 0, cyc = 0;

  swt_top swt_top_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SUPERVISION_MODE_CONFIG(mode), .LOW_FREQ_INTERNAL_OSC(osc),
    .CLEAR_SUPERVISION_INSTRUCTION(clr), .SLEEP_ENTER(slp_en), .SLEEP_ACTIVE(slp_act),
    .OSC_FAIL(ofail), .OSCILLATOR_STARTUP_TIMER(oscillator_startup_timer), .CRYSTAL_CLOCK_SOURCE(xtal),
    .DEVICE_RESET(dev_rst), .WAKE_REQUEST(wake), .TIMEOUT_STATUS_FLAG(to_flag),
    .POWERDOWN_STATUS_FLAG(pd_flag), .IRQ(irq));

  // ----------------------------------------------------------------
  // clock, pulse counters and hang limit
  // ----------------------------------------------------------------
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (dev_rst === 1'b1) n_rst <= n_rst + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer, held until ready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdc

  // slow oscillator periods, each level held four bus clocks
  task tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      osc <= 1'b1;
      repeat (4) @(posedge mclk);
      osc <= 0;
    end
  endtask : tick

  task run(input int n, input int er, input int ew);
    int r0, w0;
    r0 = n_rst;
    w0 = n_wake;
    tick(n);
    repeat (6) @(posedge mclk);
    check("reset pulses", 32'(n_rst - r0), 32'(er));
    check("wake pulses", 32'(n_wake - w0), 32'(ew));
  endtask : run

  task clear();
    @(posedge mclk);
    clr <= 1'b1;
    repeat (4) @(posedge mclk);
    clr <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : clear

  task setm(input logic [1:0] m);
    @(posedge mclk);
    mode <= m;
    repeat (4) @(posedge mclk);
  endtask : setm

  task sleep_in();
    @(posedge mclk);
    slp_en <= 1'b1;
    slp_act <= 1'b1;
    repeat (4) @(posedge mclk);
    slp_en <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : sleep_in

  task sleep_out();
    @(posedge mclk);
    slp_act <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : sleep_out

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rdc("control", swt_pkg::ADDR_CONTROL, 32'h00000016);
    rdc("status", swt_pkg::ADDR_STATUS, 32'h00000003);
    rdc("irq mask", swt_pkg::ADDR_IRQ_MASK, 32'h00000000);
    apb(1'b1, 12'h014, 32'h0000003F);
    check("unmapped error", {31'h0, err}, 32'h1);
    rdc("control kept", swt_pkg::ADDR_CONTROL, 32'h00000016);
    $display("test reset done");
  endtask : t_reset

  task t_period();
    logic [4:0] codes [4];
    int ratio;
    codes = '{5'h00, 5'h01, 5'h13, 5'h1F};
    setm(2'h3);
    rdc("status active", swt_pkg::ADDR_STATUS, 32'h00000007);
    apb(1'b1, swt_pkg::ADDR_IRQ_MASK, 32'h1);
    foreach (codes[i]) begin
      ratio = (codes[i] <= swt_pkg::PS_MAX_CODE) ? (32 << codes[i]) : 32;
      apb(1'b1, swt_pkg::ADDR_CONTROL, {26'h0, codes[i], 1'b0});
      clear();
      run(ratio - 1, 0, 0);
      rdc("count", swt_pkg::ADDR_COUNT, 32'(ratio - 1));
      run(1, 1, 0);
      rdc("count wrap", swt_pkg::ADDR_COUNT, 32'h0);
    end
    check("irq raised", {31'h0, irq}, 32'h1);
    rdc("irq status", swt_pkg::ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc("irq status cleared", swt_pkg::ADDR_IRQ_STATUS, 32'h0);
    apb(1'b1, swt_pkg::ADDR_IRQ_MASK, 32'h0);
    $display("test period done");
  endtask : t_period

  task t_clear();
    run(20, 0, 0);
    clear();
    repeat (300) @(posedge mclk);
    rdc("count cleared", swt_pkg::ADDR_COUNT, 32'h0);
    run(20, 0, 0);
    rdc("count", swt_pkg::ADDR_COUNT, 32'h14);
    $display("test clear done");
  endtask : t_clear

  task t_modes();
    setm(2'h0);
    apb(1'b1, swt_pkg::ADDR_CONTROL, 32'h1);
    run(40, 0, 0);
    rdc("count off", swt_pkg::ADDR_COUNT, 32'h0);
    apb(1'b1, swt_pkg::ADDR_CONTROL, 32'h0);
    setm(2'h1);
    run(40, 0, 0);
    apb(1'b1, swt_pkg::ADDR_CONTROL, 32'h1);
    run(32, 1, 0);
    apb(1'b1, swt_pkg::ADDR_CONTROL, 32'h0);
    setm(2'h3);
    clear();
    run(32, 1, 0);
    setm(2'h2);
    run(32, 1, 0);
    sleep_in();
    run(40, 0, 0);
    sleep_out();
    $display("test modes done");
  endtask : t_modes

  task t_sleep();
    setm(2'h3);
    apb(1'b0, swt_pkg::ADDR_IRQ_STATUS, 32'h0);
    clear();
    run(10, 0, 0);
    sleep_in();
    rdc("count at sleep", swt_pkg::ADDR_COUNT, 32'h0);
    check("powerdown flag", {31'h0, pd_flag}, 32'h0);
    check("timeout flag", {31'h0, to_flag}, 32'h1);
    run(31, 0, 0);
    run(1, 0, 1);
    check("timeout flag", {31'h0, to_flag}, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    rdc("irq status", swt_pkg::ADDR_IRQ_STATUS, 32'h2);
    run(5, 0, 0);
    sleep_out();
    rdc("count at wake", swt_pkg::ADDR_COUNT, 32'h0);
    $display("test sleep done");
  endtask : t_sleep

  task t_xtal();
    @(posedge mclk);
    xtal <= 1'b1;
    oscillator_startup_timer <= 1'b1;
    sleep_in();
    sleep_out();
    run(40, 0, 0);
    rdc("count held", swt_pkg::ADDR_COUNT, 32'h0);
    @(posedge mclk);
    oscillator_startup_timer <= 1'b0;
    run(32, 1, 0);
    @(posedge mclk);
    ofail <= 1'b1;
    run(40, 0, 0);
    @(posedge mclk);
    ofail <= 1'b0;
    $display("test start-up done");
  endtask : t_xtal

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_period();
    t_clear();
    t_modes();
    t_sleep();
    t_xtal();
    final_report();
  end
endmodule : tb_top

bind swt_top swt_top_checker #(.CNT_W(CNT_W)) swt_top_checker_i (.MCLK(MCLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SUPERVISION_MODE_CONFIG(SUPERVISION_MODE_CONFIG),
  .LOW_FREQ_INTERNAL_OSC(LOW_FREQ_INTERNAL_OSC),
  .CLEAR_SUPERVISION_INSTRUCTION(CLEAR_SUPERVISION_INSTRUCTION),
  .SLEEP_ENTER(SLEEP_ENTER), .SLEEP_ACTIVE(SLEEP_ACTIVE), .OSC_FAIL(OSC_FAIL),
  .OSCILLATOR_STARTUP_TIMER(OSCILLATOR_STARTUP_TIMER),
  .CRYSTAL_CLOCK_SOURCE(CRYSTAL_CLOCK_SOURCE), .DEVICE_RESET(DEVICE_RESET),
  .WAKE_REQUEST(WAKE_REQUEST), .TIMEOUT_STATUS_FLAG(TIMEOUT_STATUS_FLAG),
  .POWERDOWN_STATUS_FLAG(POWERDOWN_STATUS_FLAG), .IRQ(IRQ));
`default_nettype wire
